/* File: hw/rls_pkg.sv */
/*
 * Shared types and constants for the receive lane and frame status block.
 * Assumes one receive clock domain; all producers sit on that clock.
 */
`default_nettype none
package rls_pkg;
    localparam int LANES = 20;
    localparam int LANE_W = 5;
    localparam int CNT_W = 3;
    localparam int MAXLEN_W = 15;
    localparam int LEN_W = 16;
    localparam int BYTES_W = 7;
    localparam int FCS_W = 32;
    localparam int SLOTS = 4;

    localparam logic [LANE_W-1:0] LANE_NUM_RST = 5'h00;
    localparam logic [LANES-1:0] LANE_BITS_RST = 20'h00000;
    localparam logic [CNT_W-1:0] CNT_RST = 3'h0;
    localparam logic [LEN_W-1:0] LEN_RST = 16'h0000;
    localparam logic [LEN_W-1:0] LEN_SAT = 16'hFFFF;

    typedef logic [CNT_W-1:0] rls_cnt_t;
    typedef logic [LEN_W-1:0] rls_len_t;
    typedef logic [LANE_W-1:0] rls_lane_t;

    // One packet end seen by the checksum unit in a cycle
    typedef struct packed {
        logic done;
        logic [FCS_W-1:0] fcs_rx;
        logic [FCS_W-1:0] fcs_calc;
    } rls_end_s;

    // Byte stream framing of the packet currently in flight
    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic [BYTES_W-1:0] bytes;
    } rls_beat_s;
endpackage
`default_nettype wire

/* File: hw/rls_status.sv */
/*
 * Receive status outputs: lane numbering, demux flags, checksum counts,
 * truncation pulse and internal local fault.
 * Assumes all inputs come from logic on MCLK, so none is synchronised.
 */
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Each physical lane reports the 5-bit logical lane it carries.
// - Lane number means something only while that lane's sync bit is set.
// - 20-bit level flags lanes found and demultiplexed.
// - 3-bit bad checksum count pulses per cycle, stomped ones excluded.
// - Stomped means received checksum is the complement of the computed one.
// - 3-bit stomped checksum count pulses; nonzero gives the packet count.
// - Packet longer than the 15-bit maximum is truncated with one pulse.
// - Local fault level while test pattern, bad alignment or high BER.
// - Pulses may come back to back; no gaps inserted.
module rls_status #(
    parameter int SLOTS = rls_pkg::SLOTS
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [rls_pkg::LANES-1:0] LANE_SYNC,
    input wire logic [rls_pkg::LANES-1:0][rls_pkg::LANE_W-1:0] LANE_NUM_IN,
    input wire logic [rls_pkg::LANES-1:0] LANE_DEMUX_IN,
    input wire rls_pkg::rls_end_s [SLOTS-1:0] RX_END,
    input wire rls_pkg::rls_beat_s RX_BEAT,
    input wire logic [rls_pkg::MAXLEN_W-1:0] MAX_PKT_LEN,
    input wire logic TEST_PATTERN_EN,
    input wire logic LANES_ALIGNED,
    input wire logic HI_BER,
    output logic [rls_pkg::LANES-1:0][rls_pkg::LANE_W-1:0] PCSL_NUMBER,
    output logic [rls_pkg::LANES-1:0] PCSL_DEMUXED,
    output logic [rls_pkg::CNT_W-1:0] BAD_FCS,
    output logic [rls_pkg::CNT_W-1:0] STOMPED_FCS,
    output logic TRUNCATED,
    output logic TRUNC_ACTIVE,
    output logic INT_LOCAL_FAULT
);
    function automatic logic is_stomped(input rls_pkg::rls_end_s e);
        is_stomped = e.done && (e.fcs_rx == ~e.fcs_calc);
    endfunction

    function automatic logic is_bad(input rls_pkg::rls_end_s e);
        is_bad = e.done && (e.fcs_rx != e.fcs_calc) && !is_stomped(e);
    endfunction

    // Lane numbering and demux flags
    logic [rls_pkg::LANES-1:0][rls_pkg::LANE_W-1:0] num_q, num_d;
    logic [rls_pkg::LANES-1:0] demux_q, demux_d;

    genvar g;
    generate
        for (g = 0; g < rls_pkg::LANES; g++) begin : g_lane
            // A stale number is masked so a consumer ignoring sync still sees zero
            assign num_d[g] = LANE_SYNC[g] ? LANE_NUM_IN[g] : rls_pkg::LANE_NUM_RST;
        end
    endgenerate

    always_comb begin
        demux_d = LANE_DEMUX_IN;
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            num_q <= {rls_pkg::LANES{rls_pkg::LANE_NUM_RST}};
            demux_q <= rls_pkg::LANE_BITS_RST;
        end else begin
            num_q <= num_d;
            demux_q <= demux_d;
        end
    end

    // Checksum classification, one count per cycle with no holdover
    rls_pkg::rls_cnt_t bad_q, bad_d, stomp_q, stomp_d;
    logic [SLOTS-1:0] bad_v, stomp_v;

    always_comb begin
        for (int i = 0; i < SLOTS; i++) begin
            stomp_v[i] = is_stomped(RX_END[i]);
            bad_v[i] = is_bad(RX_END[i]);
        end
        bad_d = rls_pkg::rls_cnt_t'($countones(bad_v));
        stomp_d = rls_pkg::rls_cnt_t'($countones(stomp_v));
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            bad_q <= rls_pkg::CNT_RST;
            stomp_q <= rls_pkg::CNT_RST;
        end else begin
            bad_q <= bad_d;
            stomp_q <= stomp_d;
        end
    end

    // Length tracking and truncation
    rls_pkg::rls_len_t len_q, len_d;
    logic trunc_q, trunc_d, tpulse_q, tpulse_d;
    logic [rls_pkg::LEN_W:0] len_sum;
    logic over;

    always_comb begin
        len_sum = {1'b0, (RX_BEAT.sop ? rls_pkg::LEN_RST : len_q)} + {10'h000, RX_BEAT.bytes};
        over = RX_BEAT.valid && (len_sum > {2'h0, MAX_PKT_LEN}) && (RX_BEAT.sop || !trunc_q);
        len_d = len_q;
        trunc_d = trunc_q;
        tpulse_d = over;
        if (RX_BEAT.valid) begin
            // Saturate so a runaway packet cannot wrap back under the limit
            len_d = len_sum[rls_pkg::LEN_W] ? rls_pkg::LEN_SAT : len_sum[rls_pkg::LEN_W-1:0];
            if (RX_BEAT.sop) begin
                trunc_d = 1'b0;
            end
            if (over) begin
                trunc_d = 1'b1;
            end
            if (RX_BEAT.eop) begin
                len_d = rls_pkg::LEN_RST;
                trunc_d = 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            len_q <= rls_pkg::LEN_RST;
            trunc_q <= 1'b0;
            tpulse_q <= 1'b0;
        end else begin
            len_q <= len_d;
            trunc_q <= trunc_d;
            tpulse_q <= tpulse_d;
        end
    end

    // Internal local fault level
    logic fault_q, fault_d;

    always_comb begin
        fault_d = TEST_PATTERN_EN || !LANES_ALIGNED || HI_BER;
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_d;
        end
    end

    assign PCSL_NUMBER = num_q;
    assign PCSL_DEMUXED = demux_q;
    assign BAD_FCS = bad_q;
    assign STOMPED_FCS = stomp_q;
    assign TRUNCATED = tpulse_q;
    assign TRUNC_ACTIVE = trunc_q;
    assign INT_LOCAL_FAULT = fault_q;

    // Checks
    sequence s_stomp0;
        RX_END[0].done && (RX_END[0].fcs_rx == ~RX_END[0].fcs_calc);
    endsequence

    sequence s_over;
        RX_BEAT.valid && RX_BEAT.sop && !RX_BEAT.eop && ({9'h000, RX_BEAT.bytes} > {1'b0, MAX_PKT_LEN});
    endsequence

    // Bad end alone in slot 0, so the count must read exactly one
    sequence s_bad0_alone;
        RX_END[0].done && (RX_END[0].fcs_rx == (RX_END[0].fcs_calc ^ 32'h00000001)) && (RX_END[SLOTS-1:1] == '0);
    endsequence

    reset_zero_a: assert property (@(posedge MCLK) SRST |=>
        (PCSL_NUMBER == '0) && (PCSL_DEMUXED == '0) && (BAD_FCS == '0) && (STOMPED_FCS == '0)
        && !TRUNCATED && !TRUNC_ACTIVE && !INT_LOCAL_FAULT)
        else $error("outputs not cleared by reset");

    lane_num_a: assert property (@(posedge MCLK) disable iff (SRST)
        LANE_SYNC[7] |=> PCSL_NUMBER[7] == $past(LANE_NUM_IN[7]))
        else $error("lane number not forwarded");

    lane_mask_a: assert property (@(posedge MCLK) disable iff (SRST)
        !LANE_SYNC[0] |=> PCSL_NUMBER[0] == '0)
        else $error("lane number shown without sync");

    demux_flag_a: assert property (@(posedge MCLK) disable iff (SRST)
        1'b1 |=> PCSL_DEMUXED == $past(LANE_DEMUX_IN))
        else $error("demux flags lag or differ");

    stomp_excl_a: assert property (@(posedge MCLK) disable iff (SRST)
        (s_stomp0 and (RX_END[SLOTS-1:1] == '0)) |=> (BAD_FCS == '0) && (STOMPED_FCS == 3'h1))
        else $error("stomped packet counted as bad");

    bad_count_a: assert property (@(posedge MCLK) disable iff (SRST)
        (s_bad0_alone ##1 (RX_END == '0)) |-> (BAD_FCS == 3'h1) ##1 (BAD_FCS == '0))
        else $error("bad count wrong or held");

    stomp_b2b_a: assert property (@(posedge MCLK) disable iff (SRST)
        (s_stomp0 ##1 s_stomp0) |-> ##1 (STOMPED_FCS != '0) && ($past(STOMPED_FCS) != '0))
        else $error("back to back stomped counts lost");

    trunc_pulse_a: assert property (@(posedge MCLK) disable iff (SRST)
        (s_over ##1 (RX_BEAT.valid && !RX_BEAT.sop)) |-> TRUNCATED ##1 !TRUNCATED)
        else $error("truncation pulse missing or stretched");

    trunc_cause_a: assert property (@(posedge MCLK) disable iff (SRST)
        TRUNCATED |-> $past(RX_BEAT.valid) && TRUNC_ACTIVE == !$past(RX_BEAT.eop))
        else $error("truncation without an oversize beat");

    trunc_once_a: assert property (@(posedge MCLK) disable iff (SRST)
        (TRUNC_ACTIVE && RX_BEAT.valid && !RX_BEAT.sop) |=> !TRUNCATED)
        else $error("second truncation pulse in one packet");

    fault_lvl_a: assert property (@(posedge MCLK) disable iff (SRST)
        (TEST_PATTERN_EN || !LANES_ALIGNED || HI_BER)[*2] |=> INT_LOCAL_FAULT && $past(INT_LOCAL_FAULT))
        else $error("local fault not held");

    fault_clr_a: assert property (@(posedge MCLK) disable iff (SRST)
        (!TEST_PATTERN_EN && LANES_ALIGNED && !HI_BER) |=> !INT_LOCAL_FAULT)
        else $error("local fault without cause");
endmodule
`default_nettype wire

/* File: tb/rls_monitor.sv */
/*
 * Consumer model: samples the status pulses every cycle and keeps totals.
 * Assumes it sits on the same receive clock as the status block.
 */
`timescale 1ns/10ps
`default_nettype none
module rls_monitor (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [2:0] bad_fcs,
    input wire logic [2:0] stomped_fcs,
    input wire logic truncated,
    output logic [7:0] bad_tot,
    output logic [7:0] stomp_tot,
    output logic [7:0] trunc_tot
);
    // Every cycle counts as new, so adjacent pulses are never merged
    always_ff @(posedge mclk) begin
        if (srst) begin
            bad_tot <= 8'h00;
            stomp_tot <= 8'h00;
            trunc_tot <= 8'h00;
        end else begin
            bad_tot <= bad_tot + 8'(bad_fcs);
            stomp_tot <= stomp_tot + 8'(stomped_fcs);
            trunc_tot <= trunc_tot + 8'(truncated);
        end
    end
endmodule
`default_nettype wire

/* File: tb/rls_status_test.sv */
/*
 * Self-checking bench for the receive status block.
 * Assumes rls_pkg and rls_monitor are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module rls_status_test;
    logic MCLK = 1'b0;
    logic SRST = 1'b1;
    logic [19:0] sync = 20'hFFFFF;
    logic [19:0][4:0] num = '1;
    logic [19:0] dmx = 20'hFFFFF;
    rls_pkg::rls_end_s [3:0] rend = '0;
    rls_pkg::rls_beat_s beat = '0;
    logic [14:0] maxl = 15'h0064;
    logic tpg = 1'b0;
    logic algn = 1'b1;
    logic hber = 1'b1;
    logic [19:0][4:0] pn;
    logic [19:0] pd;
    logic [2:0] bad, stp;
    logic trc, tra, flt;
    logic [7:0] mbad, mstp, mtrc;
    int error_cnt = 0;
    int n_checks = 0;
    always #20 MCLK = ~MCLK;
    rls_status dut (.MCLK(MCLK), .SRST(SRST), .LANE_SYNC(sync), .LANE_NUM_IN(num), .LANE_DEMUX_IN(dmx),
        .RX_END(rend), .RX_BEAT(beat), .MAX_PKT_LEN(maxl), .TEST_PATTERN_EN(tpg), .LANES_ALIGNED(algn),
        .HI_BER(hber), .PCSL_NUMBER(pn), .PCSL_DEMUXED(pd), .BAD_FCS(bad), .STOMPED_FCS(stp),
        .TRUNCATED(trc), .TRUNC_ACTIVE(tra), .INT_LOCAL_FAULT(flt));
    rls_monitor mon (.mclk(MCLK), .srst(SRST), .bad_fcs(bad), .stomped_fcs(stp), .truncated(trc),
        .bad_tot(mbad), .stomp_tot(mstp), .trunc_tot(mtrc));
    task automatic step(int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Kind 0 good, 1 bad, 2 stomped
    task automatic fcs(int i, logic [1:0] k);
        rend[i].done = 1'b1;
        rend[i].fcs_calc = 32'h1234ABCD ^ i;
        rend[i].fcs_rx = (k == 2'h2) ? ~rend[i].fcs_calc : rend[i].fcs_calc ^ 32'(k);
    endtask
    task automatic bt(logic s, logic [6:0] b);
        beat = '{1'b1, s, 1'b0, b};
    endtask
    initial begin
        step(20);
        chk({pd, bad, stp, trc, tra, flt}, 32'h0);
        chk(pn[0], 32'h0);
        SRST = 1'b0;
        for (int i = 0; i < 20; i++)
            num[i] = 5'h13 - 5'(i);
        sync = 20'hAAAAA;
        dmx = 20'h5A5A5;
        step(2);
        for (int i = 0; i < 20; i++)
            chk(pn[i], sync[i] ? 32'(5'h13 - 5'(i)) : 32'h0);
        chk(pd, 32'h5A5A5);
        for (int k = 0; k < 4; k++) begin
            tpg = (k == 1);
            algn = (k != 2);
            hber = (k == 3);
            step(1);
            chk(flt, 32'(k != 0));
        end
        fcs(0, 2'h2); fcs(1, 2'h1); fcs(2, 2'h0); fcs(3, 2'h1);
        step(1);
        chk({bad, stp}, 32'h11);
        fcs(0, 2'h1); fcs(1, 2'h2); fcs(2, 2'h2);
        rend[3].done = 1'b0;
        step(1);
        chk({bad, stp}, 32'h0A);
        rend = '0;
        step(1);
        chk({bad, stp, mbad, mstp}, 32'h0303);
        fcs(0, 2'h1);
        step(1);
        chk({bad, stp}, 32'h08);
        rend = '0;
        step(1);
        chk({bad, stp}, 32'h00);
        fcs(0, 2'h2);
        step(1);
        chk({bad, stp}, 32'h01);
        step(1);
        chk({bad, stp}, 32'h01);
        rend = '0;
        step(1);
        chk({bad, stp}, 32'h00);
        // Exactly at the limit must not truncate
        bt(1'b1, 7'h40); step(1); chk(trc, 32'h0);
        bt(1'b0, 7'h24); step(1); chk(trc, 32'h0);
        bt(1'b0, 7'h01); step(1); chk({trc, tra}, 32'h3);
        bt(1'b0, 7'h40); step(1); chk(trc, 32'h0);
        bt(1'b1, 7'h65); step(1); chk(trc, 32'h1);
        bt(1'b1, 7'h65); step(1); chk(trc, 32'h1);
        beat = '{1'b1, 1'b0, 1'b1, 7'h01};
        step(1);
        chk({trc, tra}, 32'h0);
        beat = '0;
        step(1);
        chk({trc, mtrc}, 32'h003);
        SRST = 1'b1;
        step(1);
        chk({pd, flt, pn[1]}, 32'h0);
        summarize();
    end
    // Tests take about 43 cycles; far more than that means a hang
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
